// ---- hdl/ifm_input_function_mapper.v ----
// Input function mapper: six connectors onto logical input functions
`timescale 1ns/10ps
`include "ifm_defs.vh"
//Contract
//- Six connectors; each function holds connector number 1-6 and plus/minus polarity, except the fixed encoder and the positive-only clear-all.
//- Speed encoder fixed on connector 1, positive polarity, never reassigned.
//- Plus polarity: high pin is true; minus polarity: low pin is true.
//- Connector number zero means unassigned and always evaluates false.
//- Two product-select lines choose among products 1-3; change stops and loads.
//- While keypad lockout is true, Go, Back and navigation buttons are ignored.
//- Reject suppression starts when its input becomes true, gravity feed only.
//- In-feed photo eye defaults to connector 2 in conveyor use; reassignable.
//- Reject-confirm-1 input verifies a commanded reject into bin 1.
//- Conveyor use monitors bin-full eye as early bin 1 full notice.
//- After a product-select change, switch products without delay.
//- Clear-all-errors is positive only; clears resettable errors, keeps system failures.
module ifm_input_function_mapper (
   sys_clk,
   rst,
   in_pins,
   app_mode,
   infeed_cfg_load,
   infeed_sel,
   infeed_pol,
   rconf_sel,
   rconf_pol,
   binfull_sel,
   binfull_pol,
   psel1_sel,
   psel1_pol,
   psel2_sel,
   psel2_pol,
   lock_sel,
   lock_pol,
   rsup_sel,
   rsup_pol,
   clr_sel,
   btn_go,
   btn_back,
   btn_nav,
   reject_cmd,
   encoder_reg,
   infeed_reg,
   binfull_reg,
   reject_ok_reg,
   reject_miss_reg,
   product_reg,
   product_load_reg,
   btn_go_reg,
   btn_back_reg,
   btn_nav_reg,
   lock_reg,
   rsup_start_reg,
   clr_errors_reg,
   infeed_sel_reg
);
   input  wire                    sys_clk;
   input  wire                    rst;
   input  wire [`IFM_NUM_IN-1:0]  in_pins;
   input  wire [1:0]              app_mode;
   input  wire                    infeed_cfg_load;
   input  wire [`IFM_SEL_W-1:0]   infeed_sel;
   input  wire                    infeed_pol;
   input  wire [`IFM_SEL_W-1:0]   rconf_sel;
   input  wire                    rconf_pol;
   input  wire [`IFM_SEL_W-1:0]   binfull_sel;
   input  wire                    binfull_pol;
   input  wire [`IFM_SEL_W-1:0]   psel1_sel;
   input  wire                    psel1_pol;
   input  wire [`IFM_SEL_W-1:0]   psel2_sel;
   input  wire                    psel2_pol;
   input  wire [`IFM_SEL_W-1:0]   lock_sel;
   input  wire                    lock_pol;
   input  wire [`IFM_SEL_W-1:0]   rsup_sel;
   input  wire                    rsup_pol;
   input  wire [`IFM_SEL_W-1:0]   clr_sel;
   input  wire                    btn_go;
   input  wire                    btn_back;
   input  wire [3:0]              btn_nav;
   input  wire                    reject_cmd;
   output reg                     encoder_reg;
   output reg                     infeed_reg;
   output reg                     binfull_reg;
   output reg                     reject_ok_reg;
   output reg                     reject_miss_reg;
   output reg  [`IFM_PROD_W-1:0]  product_reg;
   output reg                     product_load_reg;
   output reg                     btn_go_reg;
   output reg                     btn_back_reg;
   output reg  [3:0]              btn_nav_reg;
   output reg                     lock_reg;
   output reg                     rsup_start_reg;
   output reg                     clr_errors_reg;
   output reg  [`IFM_SEL_W-1:0]   infeed_sel_reg;

   wire                    conveyor;
   wire                    gravity;
   wire                    infeed_act;
   wire                    rconf_act;
   wire                    binfull_act;
   wire                    psel1_act;
   wire                    psel2_act;
   wire                    lock_act;
   wire                    rsup_act;
   wire                    clr_act;
   reg                     infeed_pol_reg;
   reg                     rsup_prev_reg;
   reg                     reject_wait_reg;
   reg  [`IFM_PROD_W-1:0]  product_next;

   // Application mode decode; pipeline enables neither feed path
   assign conveyor = (app_mode == `IFM_APP_CONVEYOR);
   assign gravity  = (app_mode == `IFM_APP_GRAVITY);

   // Product code from the two select lines; 00 holds the current product
   function [`IFM_PROD_W-1:0] prod_decode;
      input                   s1;
      input                   s2;
      input [`IFM_PROD_W-1:0] cur;
      begin
         case ({s1, s2})
            2'b10:   prod_decode = `IFM_PROD_1;
            2'b01:   prod_decode = `IFM_PROD_2;
            2'b11:   prod_decode = `IFM_PROD_3;
            default: prod_decode = cur;
         endcase
      end
   endfunction

   // One tap per assignable function
   ifm_input_tap u_infeed (
      .pins   (in_pins),
      .sel    (infeed_sel_reg),
      .pol    (infeed_pol_reg),
      .active (infeed_act)
   );
   ifm_input_tap u_rconf (
      .pins   (in_pins),
      .sel    (rconf_sel),
      .pol    (rconf_pol),
      .active (rconf_act)
   );
   ifm_input_tap u_binfull (
      .pins   (in_pins),
      .sel    (binfull_sel),
      .pol    (binfull_pol),
      .active (binfull_act)
   );
   ifm_input_tap u_psel1 (
      .pins   (in_pins),
      .sel    (psel1_sel),
      .pol    (psel1_pol),
      .active (psel1_act)
   );
   ifm_input_tap u_psel2 (
      .pins   (in_pins),
      .sel    (psel2_sel),
      .pol    (psel2_pol),
      .active (psel2_act)
   );
   ifm_input_tap u_lock (
      .pins   (in_pins),
      .sel    (lock_sel),
      .pol    (lock_pol),
      .active (lock_act)
   );
   ifm_input_tap u_rsup (
      .pins   (in_pins),
      .sel    (rsup_sel),
      .pol    (rsup_pol),
      .active (rsup_act)
   );
   // Clear-all has no polarity choice; the tap is pinned to plus
   ifm_input_tap u_clr (
      .pins   (in_pins),
      .sel    (clr_sel),
      .pol    (`IFM_POL_PLUS),
      .active (clr_act)
   );

   // Next product straight from the live select taps
   always @* begin
      product_next = prod_decode(psel1_act, psel2_act, product_reg);
   end

   // In-feed assignment: defaults to connector 2, software may move it
   always @(posedge sys_clk) begin
      if (rst) begin
         infeed_sel_reg <= `IFM_SEL_INFEED;
         infeed_pol_reg <= `IFM_POL_PLUS;
      end else if (infeed_cfg_load) begin
         infeed_sel_reg <= infeed_sel;
         infeed_pol_reg <= infeed_pol;
      end
   end

   // Mapped function outputs
   always @(posedge sys_clk) begin
      if (rst) begin
         encoder_reg    <= 1'b0;
         infeed_reg     <= 1'b0;
         binfull_reg    <= 1'b0;
         lock_reg       <= 1'b0;
         clr_errors_reg <= 1'b0;
      end else begin
         // Encoder is hard wired; no select or polarity port exists for it
         encoder_reg    <= in_pins[`IFM_SEL_ENCODER - `IFM_SEL_FIRST];
         infeed_reg     <= conveyor & infeed_act;
         binfull_reg    <= conveyor & binfull_act;
         lock_reg       <= lock_act;
         clr_errors_reg <= clr_act;
      end
   end

   // Product select: same-cycle decode so a change loads at once
   always @(posedge sys_clk) begin
      if (rst) begin
         product_reg      <= `IFM_PROD_RST;
         product_load_reg <= 1'b0;
      end else begin
         product_reg      <= product_next;
         product_load_reg <= (product_next != product_reg);
      end
   end

   // Front-panel gate; held keys are masked, not queued
   always @(posedge sys_clk) begin
      if (rst) begin
         btn_go_reg   <= 1'b0;
         btn_back_reg <= 1'b0;
         btn_nav_reg  <= 4'h0;
      end else begin
         btn_go_reg   <= btn_go & ~lock_act;
         btn_back_reg <= btn_back & ~lock_act;
         btn_nav_reg  <= btn_nav & {4{~lock_act}};
      end
   end

   // Suppression start on rising edge, gravity feed only
   always @(posedge sys_clk) begin
      if (rst) begin
         rsup_prev_reg  <= 1'b0;
         rsup_start_reg <= 1'b0;
      end else begin
         rsup_prev_reg  <= rsup_act;
         rsup_start_reg <= gravity & rsup_act & ~rsup_prev_reg;
      end
   end

   // Reject verify: a command waits for the confirm eye, next command closes it
   always @(posedge sys_clk) begin
      if (rst) begin
         reject_wait_reg <= 1'b0;
         reject_ok_reg   <= 1'b0;
         reject_miss_reg <= 1'b0;
      end else begin
         reject_ok_reg   <= 1'b0;
         reject_miss_reg <= 1'b0;
         if (reject_wait_reg && rconf_act) begin
            reject_ok_reg   <= 1'b1;
            reject_wait_reg <= reject_cmd;
         end else if (reject_cmd) begin
            // A new command before confirmation means the old one missed
            reject_miss_reg <= reject_wait_reg;
            reject_wait_reg <= 1'b1;
         end
      end
   end
endmodule // ifm_input_function_mapper

// ---- hdl/ifm_defs.vh ----
// Constants for the input function mapper
`ifndef IFM_DEFS_VH
`define IFM_DEFS_VH
`define IFM_NUM_IN        6
`define IFM_SEL_W         3
`define IFM_SEL_NONE      3'h0
`define IFM_SEL_MAX       3'h6
`define IFM_SEL_FIRST     3'h1
`define IFM_SEL_ENCODER   3'h1
`define IFM_SEL_INFEED    3'h2
`define IFM_POL_PLUS      1'b0
`define IFM_POL_MINUS     1'b1
`define IFM_PROD_W        2
`define IFM_PROD_1        2'h1
`define IFM_PROD_2        2'h2
`define IFM_PROD_3        2'h3
`define IFM_PROD_RST      2'h1
`define IFM_APP_CONVEYOR  2'h0
`define IFM_APP_GRAVITY   2'h1
`define IFM_APP_PIPELINE  2'h2
`endif

// ---- hdl/ifm_input_tap.v ----
// One logical input: connector select plus polarity
`timescale 1ns/10ps
`include "ifm_defs.vh"
module ifm_input_tap (
   pins,
   sel,
   pol,
   active
);
   input  wire [`IFM_NUM_IN-1:0] pins;
   input  wire [`IFM_SEL_W-1:0]  sel;
   input  wire                   pol;
   output reg                    active;

   // Zero or out of range means unassigned and reads false
   always @* begin
      if ((sel == `IFM_SEL_NONE) || (sel > `IFM_SEL_MAX)) begin
         active = 1'b0;
      end else begin
         active = pins[sel - `IFM_SEL_FIRST] ^ pol;
      end
   end
endmodule // ifm_input_tap

// ---- verif/ifm_field_dev.sv ----
// Field side model: belt encoder and photo eyes on the connectors
`timescale 1ns/10ps
module ifm_field_dev (
   sys_clk,
   enc_run,
   eyes,
   pins
);
   input  wire       sys_clk;
   input  wire       enc_run;
   input  wire [4:0] eyes;
   output wire [5:0] pins;
   reg               enc_reg = 1'b0;
   // Encoder stands still low while the belt is stopped
   always @(negedge sys_clk) enc_reg <= enc_run & ~enc_reg;
   // Encoder always wired to connector 1, eyes on the rest
   assign pins = {eyes, enc_reg};
endmodule // ifm_field_dev

// ---- verif/ifm_input_function_mapper_asserts.sv ----
// Assertion checker for the input function mapper ports
`timescale 1ns/10ps
module ifm_map_chk (
   input wire       sys_clk,
   input wire       rst,
   input wire [5:0] in_pins,
   input wire [1:0] app_mode,
   input wire [2:0] psel1_sel,
   input wire [2:0] psel2_sel,
   input wire [2:0] clr_sel,
   input wire       btn_go,
   input wire       reject_cmd,
   input wire       encoder_reg,
   input wire       infeed_reg,
   input wire       binfull_reg,
   input wire       reject_ok_reg,
   input wire       reject_miss_reg,
   input wire [1:0] product_reg,
   input wire       product_load_reg,
   input wire       btn_go_reg,
   input wire       btn_back_reg,
   input wire [3:0] btn_nav_reg,
   input wire       lock_reg,
   input wire       rsup_start_reg,
   input wire       clr_errors_reg
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   reg live_reg;
   // High once a full cycle has passed out of reset; $past is stale before that
   always @(posedge sys_clk) live_reg <= ~rst;
   a_enc_follow: assert property (live_reg |-> encoder_reg == $past(in_pins[0]))
      else $error("encoder output does not follow connector 1");
   a_lock_mask: assert property (lock_reg |->
      !btn_go_reg && !btn_back_reg && btn_nav_reg == 4'h0)
      else $error("button passed while locked");
   a_go_pass: assert property (live_reg && !lock_reg |-> btn_go_reg == $past(btn_go))
      else $error("go button lost while unlocked");
   a_feed_conv: assert property (infeed_reg || binfull_reg |-> $past(app_mode) == 2'h0)
      else $error("conveyor eye active outside conveyor mode");
   a_rsup_grav: assert property (rsup_start_reg |->
      $past(app_mode) == 2'h1 ##1 !rsup_start_reg)
      else $error("suppression start outside gravity or too long");
   a_prod_valid: assert property (product_reg != 2'h0)
      else $error("product number out of range");
   a_load_mark: assert property (live_reg |->
      product_load_reg == (product_reg != $past(product_reg)))
      else $error("load pulse does not match product change");
   a_psel_none: assert property (live_reg &&
      $past(psel1_sel) == 3'h0 && $past(psel2_sel) == 3'h0 |-> !product_load_reg)
      else $error("unassigned selects changed product");
   a_clr_none: assert property ($past(clr_sel) == 3'h0 |-> !clr_errors_reg)
      else $error("clear-all active while unassigned");
   a_miss_cause: assert property (reject_miss_reg |-> $past(reject_cmd))
      else $error("reject miss without a new command");
   c_load: cover property (product_load_reg);
   c_rsup: cover property (rsup_start_reg);
   c_ok: cover property (reject_ok_reg);
endmodule // ifm_map_chk
bind ifm_input_function_mapper ifm_map_chk u_chk (.sys_clk, .rst, .in_pins, .app_mode,
   .psel1_sel, .psel2_sel, .clr_sel, .btn_go, .reject_cmd, .encoder_reg, .infeed_reg,
   .binfull_reg, .reject_ok_reg, .reject_miss_reg, .product_reg, .product_load_reg,
   .btn_go_reg, .btn_back_reg, .btn_nav_reg, .lock_reg, .rsup_start_reg, .clr_errors_reg);

// ---- verif/tb.sv ----
// Self-checking bench for the input function mapper
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((e) !== (a)) begin error_cnt++; \
   $display("Error %s exp %h got %h", n, e, a); end end
module tb;
   reg        sys_clk = 1'b0;
   reg        rst = 1'b1;
   reg [1:0]  app_mode = 2'h0;
   reg [2:0]  sl [0:7];
   reg [7:0]  pl = 8'h00;
   reg [3:0]  nav = 4'h0;
   reg        ifl = 1'b0, go = 1'b0, back = 1'b0, rcmd = 1'b0, enc_run = 1'b0;
   reg [4:0]  eyes = 5'h00;
   reg [1:0]  prod, e_old;
   reg [2:0]  ms;
   reg [31:0] r;
   reg        mp, pend, pt, e_lock, e_clr, e_inf, e_bin, e_ok, e_miss, e_rs, e_enc;
   integer    seed, error_cnt, tests_run, p, n, i;
   wire [5:0] in_pins;
   wire [3:0] btn_nav_reg;
   wire [2:0] infeed_sel_reg;
   wire [1:0] product_reg;
   wire       encoder_reg, infeed_reg, binfull_reg, reject_ok_reg, reject_miss_reg;
   wire       product_load_reg, btn_go_reg, btn_back_reg, lock_reg, rsup_start_reg;
   wire       clr_errors_reg;
   // Clock at 25 MHz
   initial forever #20 sys_clk = ~sys_clk;
   ifm_field_dev u_ifm_field_dev (.sys_clk, .enc_run, .eyes, .pins(in_pins));
   ifm_input_function_mapper u_ifm_input_function_mapper (.sys_clk, .rst, .in_pins,
      .app_mode, .infeed_cfg_load(ifl), .infeed_sel(sl[0]), .infeed_pol(pl[0]),
      .rconf_sel(sl[1]), .rconf_pol(pl[1]), .binfull_sel(sl[2]), .binfull_pol(pl[2]),
      .psel1_sel(sl[3]), .psel1_pol(pl[3]), .psel2_sel(sl[4]), .psel2_pol(pl[4]),
      .lock_sel(sl[5]), .lock_pol(pl[5]), .rsup_sel(sl[6]), .rsup_pol(pl[6]),
      .clr_sel(sl[7]), .btn_go(go), .btn_back(back), .btn_nav(nav), .reject_cmd(rcmd),
      .encoder_reg, .infeed_reg, .binfull_reg, .reject_ok_reg, .reject_miss_reg,
      .product_reg, .product_load_reg, .btn_go_reg, .btn_back_reg, .btn_nav_reg,
      .lock_reg, .rsup_start_reg, .clr_errors_reg, .infeed_sel_reg);
   // Connector select and polarity; select 0 or 7 reads false
   function tp(input [2:0] s, input pol);
      tp = (s >= 3'h1 && s <= 3'h6) ? in_pins[s - 3'h1] ^ pol : 1'b0;
   endfunction
   // Random inputs; in-feed reloads only in phase 1, always to a real connector
   task drive(input integer ph);
      begin
         for (i = 0; i < 8; i++) begin
            r = $random(seed);
            sl[i] = r[2:0];
            pl[i] = r[3];
         end
         r = $random(seed);
         {go, back, nav, enc_run, eyes} = r[11:0];
         app_mode = (r[13:12] == 2'h3) ? 2'h0 : r[13:12];
         rcmd = r[16:14] == 3'h0;
         ifl = ph == 1 && r[19:17] == 3'h0;
         if (ifl) sl[0] = 3'h1 + r[22:20] % 6;
      end
   endtask
   // Reference model, one cycle ahead of the outputs
   task predict;
      begin
         e_enc = in_pins[0];
         e_lock = tp(sl[5], pl[5]);
         e_clr = tp(sl[7], 1'b0);
         e_inf = app_mode == 2'h0 && tp(ms, mp);
         e_bin = app_mode == 2'h0 && tp(sl[2], pl[2]);
         e_ok = pend && tp(sl[1], pl[1]);
         e_miss = pend && rcmd && !e_ok;
         pend = rcmd || (pend && !e_ok);
         e_rs = app_mode == 2'h1 && tp(sl[6], pl[6]) && !pt;
         pt = tp(sl[6], pl[6]);
         e_old = prod;
         if (tp(sl[3], pl[3]) || tp(sl[4], pl[4])) prod = {tp(sl[4], pl[4]), tp(sl[3], pl[3])};
         // Old in-feed assignment still applies on the loading edge
         if (ifl) {ms, mp} = {sl[0], pl[0]};
      end
   endtask
   task complete_run;
      begin
         $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
         if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   // Reset for six cycles, then two random phases
   initial begin
      seed = 7918;
      {error_cnt, tests_run, pend, pt, mp} = 0;
      prod = 2'h1;
      ms = 3'h2;
      for (i = 0; i < 8; i++) sl[i] = 3'h0;
      repeat (6) @(negedge sys_clk);
      `CHK("product_rst", 2'h1, product_reg)
      `CHK("infeed_sel_rst", 3'h2, infeed_sel_reg)
      rst = 1'b0;
      for (p = 0; p < 2; p++) begin
         for (n = 0; n < 500; n++) begin
            drive(p);
            #1 predict;
            @(negedge sys_clk);
            `CHK("encoder", e_enc, encoder_reg)
            `CHK("infeed", e_inf, infeed_reg)
            `CHK("infeed_sel", ms, infeed_sel_reg)
            `CHK("binfull", e_bin, binfull_reg)
            `CHK("rej_ok", e_ok, reject_ok_reg)
            `CHK("rej_miss", e_miss, reject_miss_reg)
            `CHK("product", prod, product_reg)
            `CHK("load", prod != e_old, product_load_reg)
            `CHK("lock", e_lock, lock_reg)
            `CHK("buttons", {go, back, nav} & {6{!e_lock}}, {btn_go_reg, btn_back_reg, btn_nav_reg})
            `CHK("rsup", e_rs, rsup_start_reg)
            `CHK("clear", e_clr, clr_errors_reg)
         end
         $display("Random phase %0d done", p);
      end
      complete_run;
   end
endmodule // tb
